// ===== fan_switch.v
`timescale 1ns/1ps
module fan_switch (
	input wire clock_i,
	input wire sys_rst_i,
	input wire tick_i,
	input wire signed [15:0] temp_i,
	input wire signed [15:0] low_i,
	input wire signed [15:0] high_i,
	input wire signed [15:0] hyst_i,
	input wire [15:0] delay_i,
	output reg fan_o
);
	reg [6:0] wait_q;
	reg want_d;
	wire signed [16:0] on_at = {high_i[15], high_i} + {hyst_i[15], hyst_i};
	wire signed [16:0] off_at = {low_i[15], low_i} - {hyst_i[15], hyst_i};
	wire signed [16:0] t17 = {temp_i[15], temp_i};
	// R3 switch points with hysteresis
	always @* begin
		want_d = fan_o;
		if (t17 >= on_at)
			want_d = 1'b1;
		else if (t17 <= off_at)
			want_d = 1'b0;
	end
	// R4 delay before switching
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_q <= 7'h0;
			fan_o <= 1'b0;
		end else if (want_d == fan_o) begin
			wait_q <= 7'h0;
		end else if (tick_i) begin
			if ({9'h0, wait_q} + 16'h1 >= delay_i) begin
				fan_o <= want_d;
				wait_q <= 7'h0;
			end else begin
				wait_q <= wait_q + 7'h1;
			end
		end
	end
endmodule // fan_switch

// ===== host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire clock_i,
	input wire rsp_valid_i,
	input wire rsp_error_i,
	input wire [15:0] rsp_rdata_i,
	output reg cmd_valid_o = 1'h0,
	output reg cmd_write_o = 1'h0,
	output reg [4:0] cmd_index_o = 5'h0,
	output reg [15:0] cmd_wdata_o = 16'h0
);
	reg [15:0] rdata;
	reg err;
	task xfer(input w, input [4:0] a, input [15:0] d);
		begin
			@(negedge clock_i);
			cmd_valid_o = 1'h1;
			cmd_write_o = w;
			cmd_index_o = a;
			cmd_wdata_o = d;
			@(negedge clock_i);
			// a missing answer must not pass as data
			rdata = rsp_valid_i ? rsp_rdata_i : 16'hdead;
			err = rsp_error_i;
			cmd_valid_o = 1'h0;
			cmd_write_o = ~w;
			cmd_index_o = ~a;
			cmd_wdata_o = ~d;
		end
	endtask
endmodule // host_model

// ===== param_bank_defines.vh
`ifndef PARAM_BANK_DEFINES_VH
`define PARAM_BANK_DEFINES_VH
`define NUM_ENTRIES 26
`define IDX_SET_VALUE_ONE 5'h00
`define IDX_SET_VALUE_TWO 5'h01
`define IDX_TOLERANCE_BAND 5'h02
`define IDX_ALARM_BAND 5'h03
`define IDX_FILTER_SELECT 5'h04
`define IDX_MODE_CONFIG 5'h05
`define IDX_PROPORTIONAL_GAIN 5'h06
`define IDX_INTEGRAL_GAIN 5'h07
`define IDX_DERIVATIVE_GAIN 5'h08
`define IDX_INTEGRATOR_CLAMP 5'h09
`define IDX_OUTPUT_DUTY_CEILING 5'h0a
`define IDX_SENSOR_ONE_TRIM 5'h0b
`define IDX_SET_POINT_SLEW 5'h0c
`define IDX_SENSOR_TWO_LIMIT 5'h0d
`define IDX_SENSOR_THREE_LIMIT 5'h0e
`define IDX_SENSOR_TWO_TRIM 5'h0f
`define IDX_SENSOR_THREE_TRIM 5'h10
`define IDX_FAN_LOW_THRESHOLD 5'h11
`define IDX_FAN_HIGH_THRESHOLD 5'h12
`define IDX_FAN_HYSTERESIS 5'h13
`define IDX_FAN_SWITCH_DELAY 5'h14
`define IDX_SUPPLY_LOW_LIMIT 5'h15
`define IDX_SUPPLY_HIGH_LIMIT 5'h16
`define IDX_DEADBAND_LOW 5'h17
`define IDX_DEADBAND_HIGH 5'h18
`define IDX_DEADBAND_HYSTERESIS 5'h19
`define RST_SET_VALUE_TWO 16'h0064
`define RST_TOLERANCE_BAND 16'h0005
`define RST_ALARM_BAND 16'h0014
`define RST_PROPORTIONAL_GAIN 16'h001e
`define RST_INTEGRAL_GAIN 16'h0001
`define RST_DERIVATIVE_GAIN 16'h001e
`define RST_INTEGRATOR_CLAMP 16'h001a
`define RST_OUTPUT_DUTY_CEILING 16'h007f
`define RST_FAN_LOW_THRESHOLD 16'h0032
`define RST_FAN_HIGH_THRESHOLD 16'h012c
`define RST_FAN_SWITCH_DELAY 16'h0014
`define RST_SUPPLY_LOW_LIMIT 16'h0073
`define RST_SUPPLY_HIGH_LIMIT 16'h0122
`define RST_DEADBAND_LOW 16'h0032
`define RST_DEADBAND_HIGH 16'h012c
`define RST_DEADBAND_HYSTERESIS 16'h0014
`define RST_ZERO 16'h0000
// -999 tenths, i.e. -99.9 degrees
`define SENSOR_DISABLED 16'hfc19
`define CFG_SENSOR_SEL_LSB 0
`define CFG_MODE_LSB 2
`define CFG_AUX_OUT_LSB 4
`define CFG_AUX_IN_LSB 6
`define FAN_TICK_MS 250
`define CLOCK_HZ 10000000
`define FAN_TICK_CYCLES ((`CLOCK_HZ / 1000) * `FAN_TICK_MS)
`define FAN_DELAY_MAX 16'h007f
`define FILTER_INDEX_MAX 3'h5
`endif

// ===== tcpb_checker.sv
`timescale 1ns/1ps
module tcpb_checker (
	input wire clock_i,
	input wire sys_rst_i,
	input wire cmd_valid_i,
	input wire cmd_write_i,
	input wire [4:0] cmd_index_i,
	input wire [15:0] cmd_wdata_i,
	input wire rsp_valid_o,
	input wire rsp_error_o,
	input wire [15:0] rsp_rdata_o,
	input wire [2:0] filter_index_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire bad = cmd_index_i > 5'h19;
	answer_next_a: assert property (cmd_valid_i |=> rsp_valid_o)
		else $error("no answer");
	answer_idle_a: assert property (!cmd_valid_i |=> !rsp_valid_o)
		else $error("spurious answer");
	error_flag_a: assert property (cmd_valid_i && bad |=> rsp_error_o && rsp_rdata_o == 16'h0)
		else $error("unmapped not refused");
	error_clear_a: assert property (cmd_valid_i && !bad |=> !rsp_error_o)
		else $error("false error");
	write_echo_a: assert property (cmd_valid_i && cmd_write_i && !bad |=> rsp_rdata_o == $past(cmd_wdata_i))
		else $error("write echo wrong");
	data_hold_a: assert property (!cmd_valid_i |=> $stable(rsp_rdata_o))
		else $error("read data moved");
	error_pulse_a: assert property (rsp_error_o |-> rsp_valid_o)
		else $error("error without answer");
	filter_clamp_a: assert property (filter_index_o <= 3'h5)
		else $error("filter index too big");
endmodule // tcpb_checker

// ===== test_thermal_controller_parameter_bank.sv
`timescale 1ns/1ps
module test_thermal_controller_parameter_bank;
	localparam [415:0] RV = {16'h0014, 16'h012c, 16'h0032, 16'h0122, 16'h0073, 16'h0014,
		16'h0000, 16'h012c, 16'h0032, 16'h0000, 16'h0000, 16'hfc19, 16'hfc19, 16'h0000,
		16'h0000, 16'h007f, 16'h001a, 16'h001e, 16'h0001, 16'h001e, 16'h0000, 16'h0000,
		16'h0014, 16'h0005, 16'h0064, 16'h0000};
	reg clock_i = 1'h0;
	reg sys_rst_i = 1'h1;
	reg [15:0] t2 = 16'h0, t3 = 16'h0, ths = 16'h0;
	wire cv, cw, rv, re, pwr, fan;
	wire [4:0] ci;
	wire [15:0] cd, rd;
	wire [2:0] fi;
	wire [1:0] ss, om, ao, ai;
	integer miscompares = 0, checked = 0, seed = 32'hb3ef, i;
	reg [15:0] mem [0:25];
	reg [15:0] v;
	thermal_controller_parameter_bank #(.TICK_CYCLES(4)) dut (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_index_i(ci),
		.cmd_wdata_i(cd), .sensor_two_temp_i(t2), .sensor_three_temp_i(t3),
		.heat_sink_temp_i(ths), .rsp_valid_o(rv), .rsp_error_o(re), .rsp_rdata_o(rd),
		.power_enable_o(pwr), .fan_on_o(fan), .filter_index_o(fi), .sensor_select_o(ss),
		.operation_mode_o(om), .aux_output_cfg_o(ao), .aux_input_cfg_o(ai));
	host_model host (.clock_i(clock_i), .rsp_valid_i(rv), .rsp_error_i(re),
		.rsp_rdata_i(rd), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_index_o(ci),
		.cmd_wdata_o(cd));
	initial forever #50 clock_i = ~clock_i;
	task chk(input [15:0] s, input [15:0] e);
		begin
			checked = checked + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %0t got %h want %h", $time, s, e);
			end
		end
	endtask
	function [15:0] filt_exp(input [15:0] w);
		filt_exp = (w > 16'h0005) ? 16'h0005 : w;
	endfunction
	task acc(input w, input [4:0] a, input [15:0] d, input [15:0] e, input ee);
		begin
			host.xfer(w, a, d);
			chk(host.rdata, e);
			chk({15'h0, host.err}, {15'h0, ee});
		end
	endtask
	task lim(input [4:0] a, input [15:0] d, input p);
		begin
			acc(1'h1, a, d, d, 1'h0);
			repeat (6) @(negedge clock_i);
			chk({15'h0, pwr}, {15'h0, p});
		end
	endtask
	// fan must hold a while, then settle
	task fstep(input [15:0] t, input f0, input f1);
		begin
			ths = t;
			repeat (8) @(negedge clock_i);
			chk({15'h0, fan}, {15'h0, f0});
			repeat (36) @(negedge clock_i);
			chk({15'h0, fan}, {15'h0, f1});
		end
	endtask
	task finish_test;
		begin
			$display("counts: %0d checked, %0d miscompares", checked, miscompares);
			if (miscompares == 0 && checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		#500000;
		miscompares = miscompares + 1;
		finish_test;
	end
	initial begin
		repeat (10) @(negedge clock_i);
		sys_rst_i = 1'h0;
		for (i = 0; i < 26; i = i + 1) begin
			mem[i] = RV[i*16 +: 16];
			acc(1'h0, i[4:0], 16'h0, mem[i], 1'h0);
		end
		chk({15'h0, pwr}, 16'h1);
		$display("done: reset values");
		for (i = 0; i < 60; i = i + 1) begin
			v = $random(seed);
			acc(1'h1, v[4:0], ~v, v[4:0] < 5'h1a ? ~v : 16'h0, v[4:0] > 5'h19);
			if (v[4:0] < 5'h1a)
				mem[v[4:0]] = ~v;
		end
		for (i = 0; i < 32; i = i + 1)
			acc(1'h0, i[4:0], 16'h0, i < 26 ? mem[i] : 16'h0, i > 25);
		$display("done: random access");
		for (i = 0; i < 8; i = i + 1) begin
			v = $random(seed);
			acc(1'h1, 5'h05, v, v, 1'h0);
			acc(1'h1, 5'h04, i[15:0], i[15:0], 1'h0);
			@(negedge clock_i);
			chk({8'h0, ai, ao, om, ss}, {8'h0, v[7:0]});
			chk({13'h0, fi}, filt_exp(i[15:0]));
		end
		$display("done: config fields");
		t2 = 16'd500;
		t3 = 16'hff00;
		acc(1'h1, 5'h0e, 16'hfc19, 16'hfc19, 1'h0);
		lim(5'h0d, 16'hfc19, 1'h1);
		lim(5'h0e, 16'hfc19, 1'h1);
		lim(5'h0e, 16'hfe00, 1'h0);
		lim(5'h0e, 16'hfc19, 1'h1);
		lim(5'h0d, 16'd499, 1'h0);
		lim(5'h0d, 16'd500, 1'h1);
		$display("done: sensor limits");
		acc(1'h1, 5'h11, 16'd100, 16'd100, 1'h0);
		acc(1'h1, 5'h12, 16'd200, 16'd200, 1'h0);
		acc(1'h1, 5'h13, 16'd10, 16'd10, 1'h0);
		acc(1'h1, 5'h14, 16'd3, 16'd3, 1'h0);
		repeat (40) @(negedge clock_i);
		fstep(16'h0, 1'h0, 1'h0);
		fstep(16'd205, 1'h0, 1'h0);
		fstep(16'd210, 1'h0, 1'h1);
		fstep(16'd95, 1'h1, 1'h1);
		fstep(16'd90, 1'h1, 1'h0);
		$display("done: fan control");
		finish_test;
	end
endmodule // test_thermal_controller_parameter_bank
bind thermal_controller_parameter_bank tcpb_checker watch (.clock_i(clock_i),
	.sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
	.cmd_index_i(cmd_index_i), .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
	.rsp_error_o(rsp_error_o), .rsp_rdata_o(rsp_rdata_o), .filter_index_o(filter_index_o));

// ===== thermal_controller_parameter_bank.v
// How it works
// R1 - limit value -99.9 disables that sensor's supervision.
// R2 - sensor above its limit switches the power stage off.
// R3 - warm-side fan switches between low and high points with hysteresis.
// R4 - fan waits programmed delay before changing state; delays above 127 are cut to 127 ticks.
// R5 - entries 0,1 are set values, defaults 0 and 100.
// R6 - entries 2,3 are tolerance and alarm bands, defaults 5 and 20.
// R7 - entry 4 selects filter time constant index 0..5.
// R8 - entry 5 packs aux in, aux out, mode, sensor select fields.
// R9 - entry 11 is sensor one trim, -127..127, default 0.
// R10 - entries 13,14 are sensor limits, default disabled (-999).
// R11 - entries 15,16 are sensor two/three trims, default 0.
// R12 - entries 17,18 are fan switch temperatures, defaults 50, 300.
// R13 - entry 19 is fan hysteresis, default 0.
// R14 - entry 20 is fan delay in 250 ms units, default 20.
// R15 - entries 21,22 are supply voltage limits, defaults 115, 290.
// R16 - entries 23..25 are dead-zone limits and hysteresis.
// R17 - entries are signed 16-bit, read returns, write replaces.
`timescale 1ns/1ps
`include "param_bank_defines.vh"
module thermal_controller_parameter_bank #(
	parameter integer TICK_CYCLES = `FAN_TICK_CYCLES
) (
	input wire clock_i,
	input wire sys_rst_i,
	input wire cmd_valid_i,
	input wire cmd_write_i,
	input wire [4:0] cmd_index_i,
	input wire [15:0] cmd_wdata_i,
	input wire [15:0] sensor_two_temp_i,
	input wire [15:0] sensor_three_temp_i,
	input wire [15:0] heat_sink_temp_i,
	output reg rsp_valid_o,
	output reg rsp_error_o,
	output reg [15:0] rsp_rdata_o,
	output reg power_enable_o,
	output reg fan_on_o,
	output reg [2:0] filter_index_o,
	output reg [1:0] sensor_select_o,
	output reg [1:0] operation_mode_o,
	output reg [1:0] aux_output_cfg_o,
	output reg [1:0] aux_input_cfg_o
);
	reg [15:0] entry_q [0:`NUM_ENTRIES-1];
	reg [15:0] s2_meta_q, s2_q, s3_meta_q, s3_q, hs_meta_q, hs_q;
	reg [15:0] s2_last_q, s3_last_q, hs_last_q;
	reg [15:0] s2_word_q, s3_word_q, hs_word_q;
	reg [15:0] read_word;
	reg s2_trip_q, s3_trip_q;
	wire tick;
	wire fan_raw;
	wire index_mapped = cmd_index_i < `NUM_ENTRIES;
	// the wait counter is 7 bits, so longer delays stop at the top of the range
	wire [15:0] fan_delay = (entry_q[`IDX_FAN_SWITCH_DELAY] > `FAN_DELAY_MAX) ?
		`FAN_DELAY_MAX : entry_q[`IDX_FAN_SWITCH_DELAY];
	integer i;

	function [15:0] reset_value;
		input [4:0] idx;
		begin
			// R5 set value defaults
			if (idx == `IDX_SET_VALUE_ONE)
				reset_value = `RST_ZERO;
			else if (idx == `IDX_SET_VALUE_TWO)
				reset_value = `RST_SET_VALUE_TWO;

			// R6 band defaults
			else if (idx == `IDX_TOLERANCE_BAND)
				reset_value = `RST_TOLERANCE_BAND;
			else if (idx == `IDX_ALARM_BAND)
				reset_value = `RST_ALARM_BAND;

			// R7 R8 selector defaults
			else if (idx == `IDX_FILTER_SELECT)
				reset_value = `RST_ZERO;
			else if (idx == `IDX_MODE_CONFIG)
				reset_value = `RST_ZERO;

			// control coefficient defaults
			else if (idx == `IDX_PROPORTIONAL_GAIN)
				reset_value = `RST_PROPORTIONAL_GAIN;
			else if (idx == `IDX_INTEGRAL_GAIN)
				reset_value = `RST_INTEGRAL_GAIN;
			else if (idx == `IDX_DERIVATIVE_GAIN)
				reset_value = `RST_DERIVATIVE_GAIN;
			else if (idx == `IDX_INTEGRATOR_CLAMP)
				reset_value = `RST_INTEGRATOR_CLAMP;
			else if (idx == `IDX_OUTPUT_DUTY_CEILING)
				reset_value = `RST_OUTPUT_DUTY_CEILING;

			// R9 trim and slew defaults
			else if (idx == `IDX_SENSOR_ONE_TRIM)
				reset_value = `RST_ZERO;
			else if (idx == `IDX_SET_POINT_SLEW)
				reset_value = `RST_ZERO;

			// R10 limits start disabled
			else if (idx == `IDX_SENSOR_TWO_LIMIT)
				reset_value = `SENSOR_DISABLED;
			else if (idx == `IDX_SENSOR_THREE_LIMIT)
				reset_value = `SENSOR_DISABLED;

			// R11 trim defaults
			else if (idx == `IDX_SENSOR_TWO_TRIM)
				reset_value = `RST_ZERO;
			else if (idx == `IDX_SENSOR_THREE_TRIM)
				reset_value = `RST_ZERO;

			// R12 R13 R14 fan defaults
			else if (idx == `IDX_FAN_LOW_THRESHOLD)
				reset_value = `RST_FAN_LOW_THRESHOLD;
			else if (idx == `IDX_FAN_HIGH_THRESHOLD)
				reset_value = `RST_FAN_HIGH_THRESHOLD;
			else if (idx == `IDX_FAN_HYSTERESIS)
				reset_value = `RST_ZERO;
			else if (idx == `IDX_FAN_SWITCH_DELAY)
				reset_value = `RST_FAN_SWITCH_DELAY;

			// R15 supply defaults
			else if (idx == `IDX_SUPPLY_LOW_LIMIT)
				reset_value = `RST_SUPPLY_LOW_LIMIT;
			else if (idx == `IDX_SUPPLY_HIGH_LIMIT)
				reset_value = `RST_SUPPLY_HIGH_LIMIT;

			// R16 dead-zone defaults
			else if (idx == `IDX_DEADBAND_LOW)
				reset_value = `RST_DEADBAND_LOW;
			else if (idx == `IDX_DEADBAND_HIGH)
				reset_value = `RST_DEADBAND_HIGH;
			else if (idx == `IDX_DEADBAND_HYSTERESIS)
				reset_value = `RST_DEADBAND_HYSTERESIS;
			else
				reset_value = `RST_ZERO;
		end
	endfunction

	// true when sensor is supervised and over its limit
	function over_limit;
		input [15:0] temp;
		input [15:0] limit;
		begin
			// R1 disabled value
			if (limit == `SENSOR_DISABLED)
				over_limit = 1'b0;
			else
				over_limit = $signed(temp) > $signed(limit);
		end
	endfunction

	// R7 filter index clamp
	function [2:0] filter_index;
		input [15:0] word;
		begin
			if (word > {13'h0, `FILTER_INDEX_MAX})
				filter_index = `FILTER_INDEX_MAX;
			else
				filter_index = word[2:0];
		end
	endfunction

	// two-bit field of the configuration word
	function [1:0] cfg_field;
		input [15:0] word;
		input [31:0] lsb;
		begin
			cfg_field = word[lsb +: 2];
		end
	endfunction

	// sensor readings come from another domain
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s2_meta_q <= 16'h0;
			s2_q <= 16'h0;
			s3_meta_q <= 16'h0;
			s3_q <= 16'h0;
			hs_meta_q <= 16'h0;
			hs_q <= 16'h0;
		end else begin
			s2_meta_q <= sensor_two_temp_i;
			s2_q <= s2_meta_q;
			s3_meta_q <= sensor_three_temp_i;
			s3_q <= s3_meta_q;
			hs_meta_q <= heat_sink_temp_i;
			hs_q <= hs_meta_q;
		end
	end

	// a word torn by the crossing differs from its neighbour, so only repeats are taken
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s2_last_q <= 16'h0;
			s3_last_q <= 16'h0;
			hs_last_q <= 16'h0;
			s2_word_q <= 16'h0;
			s3_word_q <= 16'h0;
			hs_word_q <= 16'h0;
		end else begin
			s2_last_q <= s2_q;
			s3_last_q <= s3_q;
			hs_last_q <= hs_q;
			if (s2_q == s2_last_q)
				s2_word_q <= s2_q;
			if (s3_q == s3_last_q)
				s3_word_q <= s3_q;
			if (hs_q == hs_last_q)
				hs_word_q <= hs_q;
		end
	end

	// R17 read decode, unmapped numbers read zero
	always @* begin
		read_word = 16'h0;
		if (cmd_index_i == `IDX_SET_VALUE_ONE)
			read_word = entry_q[`IDX_SET_VALUE_ONE];
		else if (cmd_index_i == `IDX_SET_VALUE_TWO)
			read_word = entry_q[`IDX_SET_VALUE_TWO];
		else if (cmd_index_i == `IDX_TOLERANCE_BAND)
			read_word = entry_q[`IDX_TOLERANCE_BAND];
		else if (cmd_index_i == `IDX_ALARM_BAND)
			read_word = entry_q[`IDX_ALARM_BAND];
		else if (cmd_index_i == `IDX_FILTER_SELECT)
			read_word = entry_q[`IDX_FILTER_SELECT];
		else if (cmd_index_i == `IDX_MODE_CONFIG)
			read_word = entry_q[`IDX_MODE_CONFIG];
		else if (cmd_index_i == `IDX_PROPORTIONAL_GAIN)
			read_word = entry_q[`IDX_PROPORTIONAL_GAIN];
		else if (cmd_index_i == `IDX_INTEGRAL_GAIN)
			read_word = entry_q[`IDX_INTEGRAL_GAIN];
		else if (cmd_index_i == `IDX_DERIVATIVE_GAIN)
			read_word = entry_q[`IDX_DERIVATIVE_GAIN];
		else if (cmd_index_i == `IDX_INTEGRATOR_CLAMP)
			read_word = entry_q[`IDX_INTEGRATOR_CLAMP];
		else if (cmd_index_i == `IDX_OUTPUT_DUTY_CEILING)
			read_word = entry_q[`IDX_OUTPUT_DUTY_CEILING];
		else if (cmd_index_i == `IDX_SENSOR_ONE_TRIM)
			read_word = entry_q[`IDX_SENSOR_ONE_TRIM];
		else if (cmd_index_i == `IDX_SET_POINT_SLEW)
			read_word = entry_q[`IDX_SET_POINT_SLEW];
		else if (cmd_index_i == `IDX_SENSOR_TWO_LIMIT)
			read_word = entry_q[`IDX_SENSOR_TWO_LIMIT];
		else if (cmd_index_i == `IDX_SENSOR_THREE_LIMIT)
			read_word = entry_q[`IDX_SENSOR_THREE_LIMIT];
		else if (cmd_index_i == `IDX_SENSOR_TWO_TRIM)
			read_word = entry_q[`IDX_SENSOR_TWO_TRIM];
		else if (cmd_index_i == `IDX_SENSOR_THREE_TRIM)
			read_word = entry_q[`IDX_SENSOR_THREE_TRIM];
		else if (cmd_index_i == `IDX_FAN_LOW_THRESHOLD)
			read_word = entry_q[`IDX_FAN_LOW_THRESHOLD];
		else if (cmd_index_i == `IDX_FAN_HIGH_THRESHOLD)
			read_word = entry_q[`IDX_FAN_HIGH_THRESHOLD];
		else if (cmd_index_i == `IDX_FAN_HYSTERESIS)
			read_word = entry_q[`IDX_FAN_HYSTERESIS];
		else if (cmd_index_i == `IDX_FAN_SWITCH_DELAY)
			read_word = entry_q[`IDX_FAN_SWITCH_DELAY];
		else if (cmd_index_i == `IDX_SUPPLY_LOW_LIMIT)
			read_word = entry_q[`IDX_SUPPLY_LOW_LIMIT];
		else if (cmd_index_i == `IDX_SUPPLY_HIGH_LIMIT)
			read_word = entry_q[`IDX_SUPPLY_HIGH_LIMIT];
		else if (cmd_index_i == `IDX_DEADBAND_LOW)
			read_word = entry_q[`IDX_DEADBAND_LOW];
		else if (cmd_index_i == `IDX_DEADBAND_HIGH)
			read_word = entry_q[`IDX_DEADBAND_HIGH];
		else if (cmd_index_i == `IDX_DEADBAND_HYSTERESIS)
			read_word = entry_q[`IDX_DEADBAND_HYSTERESIS];
	end

	// R17 read and write by entry number
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (i = 0; i < `NUM_ENTRIES; i = i + 1)
				entry_q[i] <= reset_value(i[4:0]);
			rsp_valid_o <= 1'b0;
			rsp_error_o <= 1'b0;
			rsp_rdata_o <= 16'h0;
		end else begin
			rsp_valid_o <= cmd_valid_i;
			rsp_error_o <= 1'b0;
			if (cmd_valid_i) begin
				if (!index_mapped) begin
					// unmapped entries answer zero with error
					rsp_error_o <= 1'b1;
					rsp_rdata_o <= 16'h0;
				end else if (cmd_write_i) begin
					entry_q[cmd_index_i] <= cmd_wdata_i;
					rsp_rdata_o <= cmd_wdata_i;
				end else begin
					rsp_rdata_o <= read_word;
				end
			end
		end
	end

	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	// R12 R13 R14 fan settings drive the switch
	fan_switch u_fan (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick),
		.temp_i(hs_word_q),
		.low_i(entry_q[`IDX_FAN_LOW_THRESHOLD]),
		.high_i(entry_q[`IDX_FAN_HIGH_THRESHOLD]),
		.hyst_i(entry_q[`IDX_FAN_HYSTERESIS]),
		.delay_i(fan_delay),
		.fan_o(fan_raw)
	);

	// R1 R2 per-sensor trip, registered to keep the signed compare short
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s2_trip_q <= 1'b0;
			s3_trip_q <= 1'b0;
		end else begin
			s2_trip_q <= over_limit(s2_word_q, entry_q[`IDX_SENSOR_TWO_LIMIT]);
			s3_trip_q <= over_limit(s3_word_q, entry_q[`IDX_SENSOR_THREE_LIMIT]);
		end
	end

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			power_enable_o <= 1'b0;
			fan_on_o <= 1'b0;
			filter_index_o <= 3'h0;
			sensor_select_o <= 2'h0;
			operation_mode_o <= 2'h0;
			aux_output_cfg_o <= 2'h0;
			aux_input_cfg_o <= 2'h0;
		end else begin
			// R2 over-limit shutoff
			power_enable_o <= !(s2_trip_q || s3_trip_q);
			fan_on_o <= fan_raw;
			// R7 filter index, out of range clamps to 5
			filter_index_o <= filter_index(entry_q[`IDX_FILTER_SELECT]);
			// R8 configuration fields
			sensor_select_o <= cfg_field(entry_q[`IDX_MODE_CONFIG], `CFG_SENSOR_SEL_LSB);
			operation_mode_o <= cfg_field(entry_q[`IDX_MODE_CONFIG], `CFG_MODE_LSB);
			aux_output_cfg_o <= cfg_field(entry_q[`IDX_MODE_CONFIG], `CFG_AUX_OUT_LSB);
			aux_input_cfg_o <= cfg_field(entry_q[`IDX_MODE_CONFIG], `CFG_AUX_IN_LSB);
		end
	end
endmodule // thermal_controller_parameter_bank

// ===== tick_divider.v
`timescale 1ns/1ps
`include "param_bank_defines.vh"
module tick_divider #(
	parameter integer CYCLES = `FAN_TICK_CYCLES
) (
	input wire clock_i,
	input wire sys_rst_i,
	output reg tick_o
);
	reg [31:0] count_q;
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_q <= 32'h0;
			tick_o <= 1'b0;
		end else if (count_q == CYCLES - 1) begin
			count_q <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			count_q <= count_q + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule // tick_divider
